// >>> core/dac_load_map.svh
// constants for the octal converter load control: widths, codes, pin-facing figures
// assumes inclusion by both the package consumers and the design modules
`ifndef DAC_LOAD_MAP_SVH
`define DAC_LOAD_MAP_SVH
`define DL_SHIFT_BITS      24
`define DL_CODE_BITS       16
`define DL_CHANNELS        8
`define DL_ADDR_BITS       7
`define DL_ADDR_HIGH       5'h03
`define DL_CODE_ZERO       16'h0000
`define DL_CODE_MID        16'h8000
`define DL_CMD_LSB         20
`define DL_CHAN_LSB        16
`define DL_CMD_WRITE_IN    4'h1
`define DL_CMD_WRITE_BOTH  4'h3
`define DL_CMD_LOAD_SEL    4'h2
`define DL_GAIN_ONE        2'h1
`define DL_GAIN_TWO        2'h2
`endif

// >>> core/dac_load_pkg.sv
// types shared by the load control and its serial front end
// assumes dac_load_map.svh supplies the numeric constants
`include "dac_load_map.svh"
package dac_load_pkg;
  // one finished 24-bit frame split into fields
  typedef struct packed {
    logic [3:0]  cmd;
    logic [3:0]  chan;
    logic [15:0] code;
  } frame_s;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ADDR  = 2'b01,
    ST_DATA  = 2'b10,
    ST_SKIP  = 2'b11
  } link_state_e;
endpackage

// >>> core/dac_serial_rx.sv
// two-wire receiver: address match, 24-bit shift register, open-drain acknowledge
// assumes scl and sda inputs already synchronous to clk_sys
`timescale 1ns/1ps
`include "dac_load_map.svh"
module dac_serial_rx #(
  parameter int SHIFT_BITS = `DL_SHIFT_BITS
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  input  wire logic [6:0]             own_addr,
  output logic                        sda_out,
  output logic                        sda_oe,
  output logic                        frame_valid,
  output dac_load_pkg::frame_s        frame
);
  initial begin
    if (SHIFT_BITS != `DL_SHIFT_BITS) $error("shift width must be 24");
  end

  logic                 scl_q;
  logic                 sda_q;
  logic [SHIFT_BITS-1:0] shift_q;
  logic [4:0]           count_q;
  logic                 ack_q;
  dac_load_pkg::link_state_e state_q;
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_c  = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_c   = scl_in & scl_q & ~sda_q & sda_in;

  // line history for edge and start/stop detection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // bits are sampled on scl rise, one per clock, into the shift register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q     <= dac_load_pkg::ST_IDLE;
      shift_q     <= '0;
      count_q     <= 5'h00;
      ack_q       <= 1'b0;
      frame_valid <= 1'b0;
      frame       <= '0;
    end else begin
      frame_valid <= 1'b0;
      if (start_c) begin
        state_q <= dac_load_pkg::ST_ADDR;
        count_q <= 5'h00;
        ack_q   <= 1'b0;
      end else if (stop_c) begin
        state_q <= dac_load_pkg::ST_IDLE;
        ack_q   <= 1'b0;
      end else if (scl_rise && !ack_q) begin
        case (state_q)
          dac_load_pkg::ST_ADDR: begin
            shift_q <= {shift_q[SHIFT_BITS-2:0], sda_in};
            count_q <= count_q + 5'h01;
          end
          dac_load_pkg::ST_DATA: begin
            shift_q <= {shift_q[SHIFT_BITS-2:0], sda_in};
            count_q <= count_q + 5'h01;
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        if (ack_q) begin
          ack_q <= 1'b0;
        end else begin
          case (state_q)
            dac_load_pkg::ST_ADDR: begin
              if (count_q == 5'h08) begin
                // write-only slave: read requests are not acknowledged
                if (shift_q[7:1] == own_addr && !shift_q[0]) begin
                  ack_q   <= 1'b1;
                  state_q <= dac_load_pkg::ST_DATA;
                end else begin
                  state_q <= dac_load_pkg::ST_SKIP;
                end
                count_q <= 5'h00;
              end
            end
            dac_load_pkg::ST_DATA: begin
              if (count_q[2:0] == 3'h0 && count_q != 5'h00) begin
                ack_q <= 1'b1;
                if (count_q == 5'(SHIFT_BITS)) begin
                  frame_valid <= 1'b1;
                  frame       <= shift_q;
                  count_q     <= 5'h00;
                end
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // open drain: only ever pulls low, pull-up gives the high level
  assign sda_out = 1'b0;
  assign sda_oe  = ack_q;

  a_ack_low: assert property (@(posedge clk_sys) disable iff (rst)
    sda_oe |-> !sda_out) else $error("sda driven high");
endmodule

// >>> core/dac_load_ctrl.sv
// octal 16-bit converter digital control: serial frames, input and output registers
// assumes all pins synchronous to clk_sys; reset_n is the device reset pin
//
// Summary of operation
// - serial bits shift into 24-bit register
// - address bits 0 and 1 from straps
// - data line open drain, pull low only
// - span strap selects gain one or two
// - power-up to zero or midscale by strap
// - load strobe low copies pending inputs out
// - strobe async, sync, or tied low
// - reset pin acts on falling edge
// - reset low ignores load strobe
// - reset loads input and output registers
`timescale 1ns/1ps
`include "dac_load_map.svh"
module dac_load_ctrl #(
  parameter int          CHANNELS  = `DL_CHANNELS,
  parameter int          CODE_BITS = `DL_CODE_BITS,
  parameter logic [4:0]  ADDR_HIGH = `DL_ADDR_HIGH
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe,
  input  wire logic                        addr_strap_bit0,
  input  wire logic                        addr_strap_bit1,
  input  wire logic                        span_select,
  input  wire logic                        reset_level_select,
  input  wire logic                        load_strobe_n,
  input  wire logic                        reset_n,
  output logic [1:0]                       gain_q,
  output logic [CHANNELS*CODE_BITS-1:0]    out_code_q,
  output logic [CHANNELS-1:0]              out_update_q
);
  initial begin
    if (CHANNELS != `DL_CHANNELS) $error("exactly eight channels served");
    if (CODE_BITS != `DL_CODE_BITS) $error("code width must be 16");
  end

  logic [CODE_BITS-1:0] in_reg_q [CHANNELS];
  logic [CODE_BITS-1:0] out_reg_q [CHANNELS];
  logic [CHANNELS-1:0]  pending_q;
  logic                 load_strobe_n_q;
  logic                 rstn_q;
  logic                 sel_q;
  logic                 frame_valid;
  logic                 sda_out_c;
  logic                 sda_oe_c;
  dac_load_pkg::frame_s frame;
  logic [6:0]           own_addr;

  // address straps fill the two low bits of the slave address
  assign own_addr = {ADDR_HIGH, addr_strap_bit1, addr_strap_bit0};

  dac_serial_rx #(
    .SHIFT_BITS (`DL_SHIFT_BITS)
  ) u_rx (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .own_addr    (own_addr),
    .sda_out     (sda_out_c),
    .sda_oe      (sda_oe_c),
    .frame_valid (frame_valid),
    .frame       (frame)
  );

  // register the pin drive so top outputs come from flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= sda_out_c;
      sda_oe  <= sda_oe_c;
    end
  end

  // decode a channel field: bit mask of channels addressed by one frame
  function automatic logic [CHANNELS-1:0] chan_mask(input logic [3:0] chan);
    chan_mask = '0;
    if (chan < 4'(CHANNELS)) chan_mask[chan[2:0]] = 1'b1;
  endfunction

  // reset value chosen by strap level
  function automatic logic [CODE_BITS-1:0] reset_code(input logic sel);
    reset_code = sel ? `DL_CODE_MID : `DL_CODE_ZERO;
  endfunction

  // pin history; rstn edge detect makes the reset falling-edge sensitive
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_strobe_n_q <= 1'b1;
      rstn_q <= 1'b1;
      sel_q  <= 1'b0;
    end else begin
      load_strobe_n_q <= load_strobe_n;
      rstn_q <= reset_n;
      sel_q  <= reset_level_select;
    end
  end

  wire rst_fall    = rstn_q & ~reset_n;
  wire load_strobe_n_fall   = load_strobe_n_q & ~load_strobe_n;
  // a held-low strobe counts as a standing load request
  wire load_strobe_n_active = ~load_strobe_n & reset_n;
  wire [CHANNELS-1:0] wr_mask = frame_valid ? chan_mask(frame.chan) : '0;
  wire wr_in   = frame_valid && (frame.cmd == `DL_CMD_WRITE_IN);
  wire wr_both = frame_valid && (frame.cmd == `DL_CMD_WRITE_BOTH);
  wire sw_load = frame_valid && (frame.cmd == `DL_CMD_LOAD_SEL);

  // span strap picks gain; sampled each clock since it is a static tie
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gain_q <= `DL_GAIN_ONE;
    end else begin
      gain_q <= span_select ? `DL_GAIN_TWO : `DL_GAIN_ONE;
    end
  end

  // per-channel input, pending and output registers
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      logic first_q;
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          first_q <= 1'b1;
        end else begin
          first_q <= 1'b0;
        end
      end
      // strap caught at the first clock after rst release, not under reset
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          in_reg_q[g]      <= `DL_CODE_ZERO;
          out_reg_q[g]     <= `DL_CODE_ZERO;
          pending_q[g]     <= 1'b0;
          out_update_q[g]  <= 1'b0;
        end else if (first_q) begin
          in_reg_q[g]      <= reset_code(reset_level_select);
          out_reg_q[g]     <= reset_code(reset_level_select);
          out_update_q[g]  <= 1'b1;
        end else if (rst_fall) begin
          in_reg_q[g]      <= reset_code(sel_q);
          out_reg_q[g]     <= reset_code(sel_q);
          pending_q[g]     <= 1'b0;
          out_update_q[g]  <= 1'b1;
        end else begin
          out_update_q[g] <= 1'b0;
          if (wr_mask[g] && (wr_in || wr_both)) begin
            in_reg_q[g] <= frame.code;
          end
          if (wr_mask[g] && wr_both) begin
            out_reg_q[g]    <= frame.code;
            pending_q[g]    <= 1'b0;
            out_update_q[g] <= 1'b1;
          end else if (wr_mask[g] && wr_in && load_strobe_n_active) begin
            out_reg_q[g]    <= frame.code;
            pending_q[g]    <= 1'b0;
            out_update_q[g] <= 1'b1;
          end else if (wr_mask[g] && wr_in) begin
            pending_q[g] <= 1'b1;
          end else if (pending_q[g] && reset_n && (load_strobe_n_fall || load_strobe_n_active
                       || (sw_load && frame.code[g]))) begin
            out_reg_q[g]    <= in_reg_q[g];
            pending_q[g]    <= 1'b0;
            out_update_q[g] <= 1'b1;
          end
        end
      end
      assign out_code_q[g*CODE_BITS +: CODE_BITS] = out_reg_q[g];
    end
  endgenerate

  // assertions and coverage
  a_strobe_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (!reset_n && !rst_fall && !$past(rst) && !wr_both) |=> $stable(out_code_q))
    else $error("output moved while reset held");
  a_reset_loads: assert property (@(posedge clk_sys) disable iff (rst)
    (rst_fall && !$past(rst) && sel_q) |=> out_code_q[CODE_BITS-1:0] == `DL_CODE_MID)
    else $error("reset did not load midscale");
  a_reset_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (rst_fall && !$past(rst) && !sel_q) |=> out_code_q[CODE_BITS-1:0] == `DL_CODE_ZERO)
    else $error("reset did not load zero");
  a_gain_span: assert property (@(posedge clk_sys) disable iff (rst)
    span_select |=> gain_q == `DL_GAIN_TWO)
    else $error("span strap ignored");
  a_load_strobe_n_copy: assert property (@(posedge clk_sys) disable iff (rst)
    (pending_q[0] && load_strobe_n_fall && reset_n && !rst_fall && !wr_mask[0])
    |=> !pending_q[0] && out_code_q[CODE_BITS-1:0] == $past(in_reg_q[0]))
    else $error("load strobe did not copy");
  a_tied_low: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_in && wr_mask[0] && load_strobe_n_active && !rst_fall && !$past(rst))
    |=> out_code_q[CODE_BITS-1:0] == $past(frame.code))
    else $error("held strobe no transfer");
  a_powerup: assert property (@(posedge clk_sys)
    ($fell(rst) && reset_level_select) |=> out_code_q[CODE_BITS-1:0] == `DL_CODE_MID)
    else $error("power-up midscale missing");
  a_addr_strap: assert property (@(posedge clk_sys) disable iff (rst)
    own_addr[1:0] == {addr_strap_bit1, addr_strap_bit0})
    else $error("address strap mismatch");
  c_frame: cover property (@(posedge clk_sys) disable iff (rst) frame_valid);
  c_load_strobe_n: cover property (@(posedge clk_sys) disable iff (rst) load_strobe_n_fall && |pending_q);
  c_reset: cover property (@(posedge clk_sys) disable iff (rst) rst_fall);
  c_both: cover property (@(posedge clk_sys) disable iff (rst) wr_both);
endmodule

// >>> dv/twowire_master.sv
// two-wire bus master model: start, stop and byte writes with acknowledge read
// assumes clk_sys shared with the device and a pull-up resolved in the bench
`timescale 1ns/1ps
module twowire_master (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // bus idle: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // four clocks a phase keeps each scl phase above the three-clock minimum
  task automatic half();
    repeat (4) @(posedge clk_sys);
  endtask
  // one clock pulse; the wire is sampled late in the high phase
  task automatic pulse(output logic v);
    half();
    scl <= 1'b1;
    half();
    v = sda_line;
    scl <= 1'b0;
    half();
  endtask
  // data falls while clock is high
  task automatic start();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask
  // msb first, data only changes while clock is low
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      pulse(v);
    end
    sda_low <= 1'b0;
    pulse(v);
    ack = ~v;
  endtask
  // data rises while clock is high
  task automatic stop();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask
endmodule

// >>> dv/dac_load_ctrl_tb.sv
// self-checking bench for the octal converter load control
// assumes the two-wire master model drives the serial pins
`timescale 1ns/1ps
module dac_load_ctrl_tb;
  logic         clk_sys;
  logic         rst;
  logic         scl;
  logic         sda_low;
  logic         sda_out;
  logic         sda_oe;
  logic         a0;
  logic         a1;
  logic         span;
  logic         rsel;
  logic         strobe_n;
  logic         reset_n;
  logic [1:0]   gain;
  logic [127:0] codes;
  logic [7:0]   upd;
  logic [6:0]   own;
  int           failures;
  int           check_count;
  int           cyc;
  wire          sda_line;

  // pull-up wins unless some party pulls low
  assign sda_line = ~(sda_low | sda_oe);
  assign own = {5'h03, a1, a0};

  twowire_master m (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  dac_load_ctrl dut (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_bit0(a0), .addr_strap_bit1(a1), .span_select(span),
    .reset_level_select(rsel), .load_strobe_n(strobe_n), .reset_n(reset_n),
    .gain_q(gain), .out_code_q(codes), .out_update_q(upd)
  );

  // free-running clock
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard: whole run needs well under this
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_all(input logic [15:0] v);
    for (int k = 0; k < 8; k++) chk("channel", v, codes[16*k +: 16]);
  endtask

  // sync reset held three cycles, strap sampled just after release
  task automatic do_reset(input logic sel);
    rsel <= sel;
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // whole transaction; data bytes only sent when the address is taken
  task automatic frame(input logic [6:0] adr, input logic [23:0] f);
    logic ack;
    m.start();
    m.put_byte({adr, 1'b0}, ack);
    chk("addr ack", {15'h0, adr == own}, {15'h0, ack});
    if (ack) begin
      for (int i = 2; i >= 0; i--) begin
        m.put_byte(f[8*i +: 8], ack);
        chk("data ack", 16'h1, {15'h0, ack});
      end
    end
    m.stop();
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic pulse_strobe();
    strobe_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    strobe_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic t_power();
    chk_all(16'h8000);
    do_reset(1'b0);
    chk_all(16'h0000);
    chk("gain", 16'h1, {14'h0, gain});
    span <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("gain", 16'h2, {14'h0, gain});
    chk("sda_out", 16'h0, {15'h0, sda_out});
  endtask

  task automatic t_load();
    frame(own, {4'h1, 4'h3, 16'h1234});
    frame(own, {4'h1, 4'h6, 16'hBEEF});
    chk("ch3", 16'h0000, codes[48 +: 16]);
    // strobe low is seen at the next edge; the update pulse stands just after that same edge
    strobe_n <= 1'b0;
    @(posedge clk_sys);
    #1 chk("update", 16'h0048, {8'h0, upd});
    @(posedge clk_sys);
    strobe_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("ch3", 16'h1234, codes[48 +: 16]);
    chk("ch6", 16'hBEEF, codes[96 +: 16]);
    frame(own, {4'h3, 4'h0, 16'hA5A5});
    chk("ch0", 16'hA5A5, codes[0 +: 16]);
    frame(own, {4'h1, 4'h1, 16'h0F0F});
    chk("ch1", 16'h0000, codes[16 +: 16]);
    frame(own, {4'h2, 4'h0, 16'h0002});
    chk("ch1", 16'h0F0F, codes[16 +: 16]);
    frame(own ^ 7'h01, {4'h3, 4'h2, 16'h7777});
    chk("ch2", 16'h0000, codes[32 +: 16]);
  endtask

  task automatic t_held();
    strobe_n <= 1'b0;
    frame(own, {4'h1, 4'h5, 16'h1111});
    chk("ch5", 16'h1111, codes[80 +: 16]);
    strobe_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic t_reset_pin();
    rsel <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk_all(16'h8000);
    frame(own, {4'h1, 4'h4, 16'h2222});
    pulse_strobe();
    chk("ch4", 16'h8000, codes[64 +: 16]);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    pulse_strobe();
    chk("ch4", 16'h2222, codes[64 +: 16]);
  endtask

  // main sequence
  initial begin
    failures = 0;
    check_count = 0;
    cyc = 0;
    a0 = 1'b0;
    a1 = 1'b1;
    span = 1'b0;
    strobe_n = 1'b1;
    reset_n = 1'b1;
    do_reset(1'b1);
    t_power();
    t_load();
    t_held();
    t_reset_pin();
    close_out();
  end
endmodule
